/* src/cpm_pkg.sv */
// constants, types and helpers of the charge pump mode controller
// assumes a 100 MHz internal timebase clocking every file of the block
package cpm_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W         = 18;
  localparam int N_CH          = 4;
  localparam int N_SYNC        = 18;

  // times in ns, as printed
  localparam int STEP_DLY_NS = 400000;
  localparam int PWRDWN_NS   = 1500000;
  localparam int SOFT_NS     = 40000;
  localparam int DIAG_NS     = 10000;

  function automatic int cyc_up(input int ns);
    cyc_up = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : cyc_up

  localparam int STEP_DLY_CYC = cyc_up(STEP_DLY_NS);
  localparam int PWRDWN_CYC   = cyc_up(PWRDWN_NS);
  localparam int SOFT_CYC     = cyc_up(SOFT_NS);
  localparam int DIAG_CYC     = cyc_up(DIAG_NS);

  localparam logic [CNT_W-1:0] CNT_RST  = 18'h00000;
  localparam logic [N_CH-1:0]  CH_OFF   = 4'h0;
  localparam logic [N_SYNC-1:0] SYNC_RST = 18'h00000;

  typedef enum logic [1:0] {
    CPM_G1X,
    CPM_G133,
    CPM_G150,
    CPM_G200
  } cpm_gain_t;

  typedef enum logic [1:0] {
    CPM_ST_SHDN,
    CPM_ST_SOFT,
    CPM_ST_RUN,
    CPM_ST_DIAG
  } cpm_state_t;

  function automatic cpm_gain_t cpm_next_gain(input cpm_gain_t g);
    case (g)
      CPM_G1X:  cpm_next_gain = CPM_G133;
      CPM_G133: cpm_next_gain = CPM_G150;
      default:  cpm_next_gain = CPM_G200;
    endcase
  endfunction : cpm_next_gain

endpackage : cpm_pkg

/* src/cpm_tmr_if.sv */
// run/done pair between the controller and one persistence timer
// assumes both ends sit on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface cpm_tmr_if;
  logic run;
  logic done;
  modport owner (output run, input done);
  modport timer (input run, output done);
endinterface : cpm_tmr_if
`default_nettype wire

/* src/cpm_timer.sv */
// persistence timer: done rises after run has held high LIMIT cycles
// assumes run from logic on clk_sys; run low clears the count
`timescale 1ns/1ps
`default_nettype none
module cpm_timer #(
  parameter logic [cpm_pkg::CNT_W-1:0] LIMIT = 18'h00010
) (
  input  wire logic   clk_sys,
  input  wire logic   arst_n,
  input  wire logic   clk_en,
  cpm_tmr_if.timer    tif
);

  logic [cpm_pkg::CNT_W-1:0] cnt_q;
  logic [cpm_pkg::CNT_W-1:0] cnt_d;
  logic                      done_q;
  logic                      done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (!tif.run) begin
      cnt_d  = cpm_pkg::CNT_RST;
      done_d = 1'b0;
    end else if (!done_q) begin
      cnt_d = cnt_q + 18'h00001;
      if (cnt_q == LIMIT - 18'h00001) begin
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= cpm_pkg::CNT_RST;
      done_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign tif.done = done_q;

endmodule : cpm_timer
`default_nettype wire

/* src/cpm_ctrl.sv */
// gain mode, channel gating and protection control of the pump driver
// assumes analog flags arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module cpm_ctrl #(
  parameter logic [cpm_pkg::CNT_W-1:0] STEP_CYC =
    cpm_pkg::CNT_W'(cpm_pkg::STEP_DLY_CYC),
  parameter logic [cpm_pkg::CNT_W-1:0] SHDN_CYC =
    cpm_pkg::CNT_W'(cpm_pkg::PWRDWN_CYC)
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       en_pin,
  input  wire logic       unity_ok,
  input  wire logic [3:0] ch_low,
  input  wire logic [3:0] ch_open,
  input  wire logic [3:0] ch_tied,
  input  wire logic       ovp_trip,
  input  wire logic       temp_hot,
  input  wire logic       temp_cool,
  input  wire logic       uvlo,
  output logic      [1:0] gain_mode,
  output logic      [3:0] channel_on,
  output logic            pump_switch_en,
  output logic            unity_return_hysteresis,
  output logic            shutdown,
  output logic            soft_start,
  output logic            diag_active,
  output logic            therm_shdn
);

  localparam logic [cpm_pkg::CNT_W-1:0] SOFT_LIM =
    cpm_pkg::CNT_W'(cpm_pkg::SOFT_CYC);
  localparam logic [cpm_pkg::CNT_W-1:0] DIAG_LIM =
    cpm_pkg::CNT_W'(cpm_pkg::DIAG_CYC);

  logic [cpm_pkg::N_SYNC-1:0] sync1_q;
  logic [cpm_pkg::N_SYNC-1:0] sync2_q;
  logic                       en_s;
  logic                       unity_s;
  logic [3:0]                 low_s;
  logic [3:0]                 open_s;
  logic [3:0]                 tied_s;
  logic                       ovp_s;
  logic                       hot_s;
  logic                       cool_s;
  logic                       uvlo_s;

  cpm_pkg::cpm_state_t        state_q;
  cpm_pkg::cpm_state_t        state_d;
  cpm_pkg::cpm_gain_t         mode_q;
  cpm_pkg::cpm_gain_t         mode_d;
  logic [3:0]                 open_q;
  logic [3:0]                 open_d;
  logic                       therm_q;
  logic                       therm_d;
  logic                       step_clr_q;
  logic                       step_clr_d;
  logic                       ovp_prev_q;
  logic [cpm_pkg::CNT_W-1:0]  diag_q;
  logic [cpm_pkg::CNT_W-1:0]  diag_d;
  logic [3:0]                 ch_on_q;
  logic [3:0]                 ch_on_d;
  logic                       pump_q;
  logic                       pump_d;
  logic [3:0]                 excl;
  logic                       insuff;
  logic                       live;
  logic                       new_open;
  logic                       ovp_rise;
  logic                       step_ok;

  cpm_tmr_if up_if ();
  cpm_tmr_if sd_if ();
  cpm_tmr_if sf_if ();

  // two-stage synchroniser for every pin-side flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= cpm_pkg::SYNC_RST;
      sync2_q <= cpm_pkg::SYNC_RST;
    end else if (clk_en) begin
      sync1_q <= {en_pin, unity_ok, ch_low, ch_open, ch_tied,
                  ovp_trip, temp_hot, temp_cool, uvlo};
      sync2_q <= sync1_q;
    end
  end

  assign {en_s, unity_s, low_s, open_s, tied_s,
          ovp_s, hot_s, cool_s, uvlo_s} = sync2_q;

  assign excl     = open_q | tied_s;
  assign insuff   = |(low_s & ~excl);
  assign live     = (state_q == cpm_pkg::CPM_ST_SOFT) ||
                    (state_q == cpm_pkg::CPM_ST_RUN);
  assign new_open = live && |(open_s & ~excl);
  assign ovp_rise = ovp_s && !ovp_prev_q;
  assign step_ok  = up_if.done && !step_clr_q;

  // step delay only counts while insufficiency persists
  assign up_if.run = live && insuff && !unity_s && !step_clr_q &&
                     (mode_q != cpm_pkg::CPM_G200);
  // shutdown counter clears whenever enable is high
  assign sd_if.run = !en_s && (state_q != cpm_pkg::CPM_ST_SHDN);
  assign sf_if.run = (state_q == cpm_pkg::CPM_ST_SOFT);

  cpm_timer #(.LIMIT(STEP_CYC)) u_step (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .tif     (up_if)
  );

  cpm_timer #(.LIMIT(SHDN_CYC)) u_shdn (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .tif     (sd_if)
  );

  cpm_timer #(.LIMIT(SOFT_LIM)) u_soft (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .tif     (sf_if)
  );

  always_comb begin
    state_d    = state_q;
    mode_d     = mode_q;
    open_d     = open_q;
    therm_d    = therm_q;
    step_clr_d = 1'b0;
    diag_d     = diag_q;
    if (hot_s) begin
      therm_d = 1'b1;
    end else if (cool_s) begin
      therm_d = 1'b0;
    end
    case (state_q)
      cpm_pkg::CPM_ST_SHDN: begin
        mode_d = cpm_pkg::CPM_G1X;
        open_d = cpm_pkg::CH_OFF;
        if (en_s) begin
          state_d = cpm_pkg::CPM_ST_SOFT;
        end
      end
      cpm_pkg::CPM_ST_SOFT: begin
        if (sf_if.done) begin
          state_d = cpm_pkg::CPM_ST_RUN;
        end
      end
      cpm_pkg::CPM_ST_DIAG: begin
        diag_d = diag_q + 18'h00001;
        if (diag_q == DIAG_LIM - 18'h00001) begin
          state_d = cpm_pkg::CPM_ST_RUN;
          diag_d  = cpm_pkg::CNT_RST;
        end
      end
      default: begin
      end
    endcase
    if (live) begin
      if (new_open) begin
        state_d    = cpm_pkg::CPM_ST_DIAG;
        open_d     = open_q | open_s;
        mode_d     = cpm_pkg::CPM_G1X;
        step_clr_d = 1'b1;
        diag_d     = cpm_pkg::CNT_RST;
      end else if (mode_q != cpm_pkg::CPM_G1X && unity_s) begin
        mode_d     = cpm_pkg::CPM_G1X;
        step_clr_d = 1'b1;
      end else if (step_ok) begin
        mode_d     = cpm_pkg::cpm_next_gain(mode_q);
        step_clr_d = 1'b1;
      end
    end
    if (ovp_rise && state_q != cpm_pkg::CPM_ST_SHDN) begin
      state_d    = cpm_pkg::CPM_ST_DIAG;
      mode_d     = cpm_pkg::CPM_G1X;
      open_d     = cpm_pkg::CH_OFF;
      step_clr_d = 1'b1;
      diag_d     = cpm_pkg::CNT_RST;
    end
    if (sd_if.done || uvlo_s || therm_d) begin
      state_d = cpm_pkg::CPM_ST_SHDN;
      mode_d  = cpm_pkg::CPM_G1X;
      diag_d  = cpm_pkg::CNT_RST;
    end
    // channels follow enable unless shut down or open/tied; the pump does not
    if (state_d != cpm_pkg::CPM_ST_SHDN && en_s) begin
      ch_on_d = ~(open_d | tied_s);
    end else begin
      ch_on_d = cpm_pkg::CH_OFF;
    end
    pump_d = (state_d != cpm_pkg::CPM_ST_SHDN) &&
             (mode_d != cpm_pkg::CPM_G1X);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= cpm_pkg::CPM_ST_SHDN;
      mode_q     <= cpm_pkg::CPM_G1X;
      open_q     <= cpm_pkg::CH_OFF;
      therm_q    <= 1'b0;
      step_clr_q <= 1'b0;
      ovp_prev_q <= 1'b0;
      diag_q     <= cpm_pkg::CNT_RST;
      ch_on_q    <= cpm_pkg::CH_OFF;
      pump_q     <= 1'b0;
    end else if (clk_en) begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      open_q     <= open_d;
      therm_q    <= therm_d;
      step_clr_q <= step_clr_d;
      ovp_prev_q <= ovp_s;
      diag_q     <= diag_d;
      ch_on_q    <= ch_on_d;
      pump_q     <= pump_d;
    end
  end

  assign gain_mode               = mode_q;
  assign channel_on              = ch_on_q;
  assign pump_switch_en          = pump_q;
  assign unity_return_hysteresis = (mode_q != cpm_pkg::CPM_G1X);
  assign shutdown                = (state_q == cpm_pkg::CPM_ST_SHDN);
  assign soft_start              = (state_q == cpm_pkg::CPM_ST_SOFT);
  assign diag_active             = (state_q == cpm_pkg::CPM_ST_DIAG);
  assign therm_shdn              = therm_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n || !clk_en);

  chan_off_a: assert property (!en_s |=> channel_on == 4'h0)
    else $error("channels stayed on with enable low");
  shdn_unity_a: assert property (shutdown |-> mode_q == cpm_pkg::CPM_G1X)
    else $error("shutdown left a gain above unity");
  step_one_a: assert property ((mode_q != $past(mode_q) &&
      mode_q != cpm_pkg::CPM_G1X) |->
      (mode_q == cpm_pkg::cpm_next_gain($past(mode_q)) && $past(up_if.done)))
    else $error("gain stepped without full delay or skipped");
  unity_ret_a: assert property ((live && mode_q != cpm_pkg::CPM_G1X &&
      unity_s && !sd_if.done && !uvlo_s && !hot_s && !therm_q) |=>
      mode_q == cpm_pkg::CPM_G1X)
    else $error("no direct return to unity");
  shdn_time_a: assert property (($rose(shutdown) && !$past(uvlo_s) &&
      !$past(therm_d)) |-> $past(sd_if.done))
    else $error("shutdown entered before enable low time");
  pump_static_a: assert property (pump_switch_en |->
      mode_q != cpm_pkg::CPM_G1X)
    else $error("pump switching in unity mode");
  all_open_a: assert property ((open_q == 4'hf && state_q ==
      cpm_pkg::CPM_ST_RUN) |-> mode_q == cpm_pkg::CPM_G1X)
    else $error("all channels open but gain above unity");
  therm_off_a: assert property (therm_shdn |->
      (channel_on == 4'h0 && !pump_switch_en))
    else $error("outputs live during thermal shutdown");
  uvlo_a: assert property (uvlo_s |=> shutdown && channel_on == 4'h0)
    else $error("undervoltage did not shut down");
  tied_a: assert property ((channel_on & $past(tied_s)) == 4'h0)
    else $error("rail-tied channel enabled");
  ovp_a: assert property (ovp_rise |=> mode_q == cpm_pkg::CPM_G1X)
    else $error("over-voltage did not reset gain");
  wake_a: assert property ($rose(en_s) && shutdown && !uvlo_s &&
      !therm_d |=> soft_start)
    else $error("wake without soft-start");

  top_gain_c: cover property (mode_q == cpm_pkg::CPM_G200);
  enter_shdn_c: cover property ($rose(shutdown));
  diag_run_c: cover property ($rose(diag_active));
  pwm_edge_c: cover property (!shutdown && $rose(en_s) ##1 channel_on != 4'h0);
  wake_soft_c: cover property ($rose(soft_start));

endmodule : cpm_ctrl
`default_nettype wire

/* verification/cpm_host_model.sv */
// host enable and pwm source driving the controller enable pin
// assumes the clk_sys timebase; en_pin changes only after rising edges
`timescale 1ns/1ps
`default_nettype none
module cpm_host_model (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        pwm_on,
  input  wire logic        lvl,
  input  wire logic [15:0] lo_cyc,
  input  wire logic [15:0] hi_cyc,
  output logic             en_pin
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      en_pin <= 1'h0;
      cnt_q  <= 16'h0000;
    end else if (!pwm_on) begin
      en_pin <= lvl;
      cnt_q  <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= (en_pin ? hi_cyc : lo_cyc)) begin
      en_pin <= ~en_pin;
      cnt_q  <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : cpm_host_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench of the pump mode controller with a host model
// assumes shortened step and shutdown counts; clk_en held high
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int STEP = 20;
  localparam int SHDN = 50;
  logic clk_sys = 1'h0, arst_n = 1'h0, unity_ok = 1'h1, ovp_trip = 1'h0;
  logic temp_hot = 1'h0, temp_cool = 1'h0, uvlo = 1'h0;
  logic pwm_on = 1'h0, lvl = 1'h0, en_pin;
  logic [3:0] ch_low = 4'h0, ch_open = 4'h0, ch_tied = 4'h0, channel_on;
  logic [15:0] lo_cyc = 16'h0010, hi_cyc = 16'h001e;
  logic [1:0] gain_mode;
  logic pump_switch_en, hyst, shutdown, soft_start, diag_active, therm;
  logic [3:0] m_mask;
  logic en_hist[$];
  logic [31:0] rnd = 32'd35628;
  int n_mismatch = 0, checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  // model: channel_on trails en_pin by three edges
  always @(posedge clk_sys) begin
    en_hist.push_back(en_pin);
    if (en_hist.size() > 3) void'(en_hist.pop_front());
  end
  function automatic logic [7:0] on_of(input logic en, input logic [3:0] m);
    on_of = en ? {4'h0, ~m} : 8'h00;
  endfunction : on_of
  cpm_host_model host (.clk_sys(clk_sys), .arst_n(arst_n), .pwm_on(pwm_on),
    .lvl(lvl), .lo_cyc(lo_cyc), .hi_cyc(hi_cyc), .en_pin(en_pin));
  cpm_ctrl #(.STEP_CYC(18'h00014), .SHDN_CYC(18'h00032)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'h1), .en_pin(en_pin),
    .unity_ok(unity_ok), .ch_low(ch_low), .ch_open(ch_open),
    .ch_tied(ch_tied), .ovp_trip(ovp_trip), .temp_hot(temp_hot),
    .temp_cool(temp_cool), .uvlo(uvlo), .gain_mode(gain_mode),
    .channel_on(channel_on), .pump_switch_en(pump_switch_en),
    .unity_return_hysteresis(hyst), .shutdown(shutdown),
    .soft_start(soft_start), .diag_active(diag_active),
    .therm_shdn(therm));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs
  task automatic check(input string nm, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic look(input int n);
    cyc(n);
    @(negedge clk_sys);
  endtask : look
  task automatic step(input int g, input int pre);
    int n;
    n = pre;
    while (gain_mode === 2'(g - 1) && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check("gain", 8'(gain_mode), 8'(g));
    check("step_wait", 8'(n >= STEP), 8'h01);
    check("step_late", 8'(n <= STEP + 4), 8'h01);
  endtask : step
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    cyc(60000);
    n_mismatch++;
    results();
  end
  initial begin
    int st;
    logic lastv;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'h1;
    rnd = xs(rnd);
    ch_tied <= rnd[3:0] & 4'hc;
    m_mask = rnd[3:0] & 4'hc;
    look(1);
    check("gain", 8'(gain_mode), 8'h00);
    check("shdn", 8'(shutdown), 8'h01);
    cyc(1);
    lvl <= 1'h1;
    look(6);
    check("soft", 8'(soft_start), 8'h01);
    check("ch_on", 8'(channel_on), on_of(1'h1, m_mask));
    look(cpm_pkg::SOFT_CYC);
    check("soft", 8'(soft_start), 8'h00);
    check("gain", 8'(gain_mode), 8'h00);
    check("pump", 8'(pump_switch_en), 8'h00);
    cyc(1);
    unity_ok <= 1'h0;
    ch_low <= 4'h1;
    cyc(12);
    ch_low <= 4'h0;
    cyc(1);
    ch_low <= 4'h1;
    look(12);
    check("gain", 8'(gain_mode), 8'h00);
    for (int g = 1; g < 4; g++) step(g, (g == 1) ? 12 : 0);
    look(100);
    check("gain", 8'(gain_mode), 8'h03);
    check("hyst", 8'(hyst), 8'h01);
    check("pump", 8'(pump_switch_en), 8'h01);
    cyc(1);
    unity_ok <= 1'h1;
    repeat (6) begin
      @(negedge clk_sys);
      check("ret", 8'(gain_mode == 2'h0 || gain_mode == 2'h3), 8'h01);
    end
    check("gain", 8'(gain_mode), 8'h00);
    check("pump", 8'(pump_switch_en), 8'h00);
    check("hyst", 8'(hyst), 8'h00);
    cyc(1);
    rnd = xs(rnd);
    lo_cyc <= 16'(rnd % 31 + 10);
    pwm_on <= 1'h1;
    st = 0;
    lastv = 1'h1;
    repeat (400) begin
      @(negedge clk_sys);
      st = (en_pin === lastv) ? st + 1 : 0;
      lastv = en_pin;
      if (st >= 4)
        check("pwm_on", 8'(channel_on), on_of(en_pin, m_mask));
      check("pwm_model", 8'(channel_on), on_of(en_hist[0], m_mask));
      check("pwm_up", 8'({shutdown, soft_start}), 8'h00);
    end
    cyc(1);
    pwm_on <= 1'h0;
    unity_ok <= 1'h0;
    ch_low <= 4'h2;
    ch_open <= 4'h2;
    m_mask = m_mask | 4'h2;
    look(6);
    check("diag", 8'(diag_active), 8'h01);
    check("ch_on", 8'(channel_on), on_of(1'h1, m_mask));
    look(cpm_pkg::DIAG_CYC + 60);
    check("diag", 8'(diag_active), 8'h00);
    check("gain", 8'(gain_mode), 8'h00);
    cyc(1);
    ch_open <= 4'hf;
    ch_low <= 4'hf;
    look(cpm_pkg::DIAG_CYC + 100);
    check("gain", 8'(gain_mode), 8'h00);
    check("ch_on", 8'(channel_on), 8'h00);
    cyc(1);
    ovp_trip <= 1'h1;
    ch_open <= 4'h0;
    ch_low <= 4'h1;
    m_mask = ch_tied;
    look(6);
    check("diag", 8'(diag_active), 8'h01);
    look(cpm_pkg::DIAG_CYC);
    check("ch_on", 8'(channel_on), on_of(1'h1, m_mask));
    step(1, 3);
    cyc(1);
    ovp_trip <= 1'h0;
    temp_hot <= 1'h1;
    look(6);
    check("therm", 8'({therm, shutdown, channel_on}), 8'h30);
    cyc(1);
    temp_hot <= 1'h0;
    temp_cool <= 1'h1;
    look(10);
    check("therm", 8'({therm, shutdown}), 8'h00);
    cyc(1);
    temp_cool <= 1'h0;
    uvlo <= 1'h1;
    look(6);
    check("uvlo", 8'({shutdown, channel_on}), 8'h10);
    cyc(1);
    uvlo <= 1'h0;
    look(cpm_pkg::SOFT_CYC + 20);
    cyc(1);
    lvl <= 1'h0;
    look(6);
    check("ch_off", 8'(channel_on), 8'h00);
    look(SHDN - 20);
    check("shdn", 8'(shutdown), 8'h00);
    look(30);
    check("shdn", 8'(shutdown), 8'h01);
    results();
  end
endmodule : testbench
`default_nettype wire
